/* hdl/smem_i2c_slave.sv */
`timescale 1ns/1ns
module smem_i2c_slave
    import smem_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = 4'h5        // Device type code, value arbitrary
) (
    input  wire logic clk_sys_in,                // System clock, 100 MHz
    input  wire logic nrst_in,                   // Synchronous reset, active low
    input  wire logic scl_clk_in,                // Serial clock from the master
    input  wire logic sda_in,                    // Serial data line level
    output wire logic sda_out,                   // Serial data drive value
    output wire logic sda_oe_out,                // Serial data drive enable
    output wire logic bus_busy_out               // Between start and stop
);

    // =========================================================
    // System domain: line watchers
    // =========================================================
    logic        scl_s1_r;                       // Clock line sync, first stage
    logic        scl_s2_r;                       // Clock line sync, second stage
    logic        sda_s1_r;                       // Data line sync, first stage
    logic        sda_s2_r;                       // Data line sync, second stage
    logic        scl_d_r;                        // Clock line, one cycle older
    logic        sda_d_r;                        // Data line, one cycle older
    logic        start_det;                      // Start seen this cycle
    logic        stop_det;                       // Stop seen this cycle
    logic        link_rst_r;                     // Hold link logic in reset
    logic        arm_r;                          // Start seen, wait clock low
    logic        por_rst_r;                      // Power-on reset to link
    logic        busy_r;                         // Bus owned by a transfer

    // Two-stage synchronisers for both bus lines
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
        end else begin
            scl_s1_r <= scl_clk_in;
            scl_s2_r <= scl_s1_r;
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
        end
    end

    // Delayed copies for edge detection on the second stage
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s2_r;
            sda_d_r <= sda_s2_r;
        end
    end

    // Data falling while clock stays high
    assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    // Data rising while clock stays high
    assign stop_det  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

    // Link reset: raised by start or stop, dropped once clock falls
    // after a start. The release lands in the low half of the clock,
    // far from any edge the link logic acts on.
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            link_rst_r <= 1'b1;
            arm_r      <= 1'b0;
        end else if (start_det) begin
            // Abort and prepare for a new slave address
            link_rst_r <= 1'b1;
            arm_r      <= 1'b1;
        end else if (stop_det) begin
            // Abort and stay idle until the next start
            link_rst_r <= 1'b1;
            arm_r      <= 1'b0;
        end else if (arm_r && !scl_s2_r) begin
            // Clock low after start: free the link
            link_rst_r <= 1'b0;
            arm_r      <= 1'b0;
        end
    end

    // Power-on reset for state that survives transfers
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            por_rst_r <= 1'b1;
        end else begin
            por_rst_r <= 1'b0;
        end
    end

    // Bus busy flag, start sets and stop clears
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            busy_r <= 1'b0;
        end else if (start_det) begin
            busy_r <= 1'b1;
        end else if (stop_det) begin
            busy_r <= 1'b0;
        end
    end

    assign bus_busy_out = busy_r;

    // =========================================================
    // Link domain: serial engine on the master's clock
    // =========================================================
    logic [7:0]  mem [MEM_DEPTH];                // Byte array, geometry
    smem_state_t state_r;                        // Transfer state
    logic [3:0]  bit_cnt_r;                      // Bit position in byte frame
    logic [7:0]  shift_r;                        // Incoming byte shifter
    logic [2:0]  page_r;                         // Latched page select
    logic        rw_r;                           // Latched direction bit
    logic [10:0] addr_r;                         // Address latch, row and page
    logic [7:0]  rd_r;                           // Byte being sent out
    logic        oe_r;                           // Pull data line low
    logic [7:0]  byte_in;                        // Byte with current bit
    logic        byte_done;                      // Eighth bit sampled now
    logic        type_ok;                        // Device type matches

    // Shift in most significant bit first
    assign byte_in   = {shift_r[6:0], sda_in};
    assign byte_done = (bit_cnt_r == BIT_LAST);
    // Compare the upper nibble with the device type
    assign type_ok   = (byte_in[TYPE_HI:TYPE_LO] == DEV_TYPE);

    // Sampling side: bits are taken on the rising clock edge
    always_ff @(posedge scl_clk_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            // First byte after start is the slave address
            state_r   <= ST_ADDR;
            bit_cnt_r <= BIT_FIRST;
            shift_r   <= 8'h00;
            page_r    <= PAGE_RST;
            rw_r      <= 1'b0;
        end else if (bit_cnt_r == BIT_ACK) begin
            // Ninth clock: acknowledge slot closes
            bit_cnt_r <= BIT_FIRST;
            case (state_r)
                ST_ADDR: begin
                    // Direction bit picks the next phase
                    state_r <= rw_r ? ST_RDATA : ST_WADDR;
                end
                ST_WADDR: begin
                    // Word address taken, data follows
                    state_r <= ST_WDATA;
                end
                ST_RDATA: begin
                    // Master acknowledge continues, otherwise stop
                    state_r <= sda_in ? ST_IGNORE : ST_RDATA;
                end
                default: begin
                    // Write data and idle stay where they are
                    state_r <= state_r;
                end
            endcase
        end else if (state_r != ST_IGNORE) begin
            // Ordinary data bit
            bit_cnt_r <= bit_cnt_r + 4'h1;
            shift_r   <= byte_in;
            if (byte_done && state_r == ST_ADDR) begin
                // Latch page and direction from the address byte
                page_r <= byte_in[PAGE_HI:PAGE_LO];
                rw_r   <= byte_in[RW_BIT];
                if (!type_ok) begin
                    // Not for us: stay off the bus
                    state_r <= ST_IGNORE;
                end
            end
        end
    end

    // Address latch, kept across transfers, only power-on clears it
    always_ff @(posedge scl_clk_in or posedge por_rst_r) begin
        if (por_rst_r) begin
            addr_r <= ADDR_RST;
        end else if (!link_rst_r && byte_done) begin
            case (state_r)
                ST_ADDR: begin
                    // Read: new page, keep the low row bits
                    if (type_ok && byte_in[RW_BIT]) begin
                        addr_r <= {byte_in[PAGE_HI:PAGE_LO],
                                   addr_r[ROW_W-1:0]};
                    end
                end
                ST_WADDR: begin
                    // Write: page plus word address
                    addr_r <= {page_r, byte_in};
                end
                ST_WDATA, ST_RDATA: begin
                    // Step before the acknowledge, natural wrap at the top
                    addr_r <= addr_r + 11'h001;
                end
                default: begin
                    addr_r <= addr_r;
                end
            endcase
        end
    end

    // Array write on the eighth bit, done before the acknowledge
    always_ff @(posedge scl_clk_in) begin
        if (!link_rst_r && byte_done && state_r == ST_WDATA) begin
            mem[addr_r] <= byte_in;
        end
    end

    // Driving side: the data line changes on the falling clock edge
    always_ff @(negedge scl_clk_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            oe_r <= 1'b0;
            rd_r <= 8'h00;
        end else if (bit_cnt_r == BIT_ACK) begin
            // Acknowledge our received bytes, release on read slots
            oe_r <= (state_r == ST_ADDR) ||
                    (state_r == ST_WADDR) ||
                    (state_r == ST_WDATA);
        end else if (state_r == ST_RDATA) begin
            if (bit_cnt_r == BIT_FIRST) begin
                // Fetch the byte at the latch, send its top bit
                rd_r <= mem[addr_r];
                oe_r <= ~mem[addr_r][DATA_W-1];
            end else begin
                // Remaining bits, top down
                oe_r <= ~rd_r[~bit_cnt_r[2:0]];
            end
        end else begin
            // Receiving or idle: line released
            oe_r <= 1'b0;
        end
    end

    // Open drain: only ever pull low, never touch the clock
    assign sda_out    = 1'b0;
    assign sda_oe_out = oe_r;

endmodule

/* hdl/smem_pkg.sv */
package smem_pkg;

    // =========================================================
    // Array geometry
    localparam int          ADDR_W    = 11;      // Full byte address width
    localparam int          DATA_W    = 8;       // Byte width
    localparam int          MEM_DEPTH = 2048;    // Number of byte locations
    localparam int          ROW_W     = 8;       // Row part of the address
    localparam int          PAGE_W    = 3;       // Segment / page part

    // =========================================================
    // Slave address byte fields
    localparam int          TYPE_HI   = 7;       // Device type field, top
    localparam int          TYPE_LO   = 4;       // Device type field, bottom
    localparam int          PAGE_HI   = 3;       // Page select, top
    localparam int          PAGE_LO   = 1;       // Page select, bottom
    localparam int          RW_BIT    = 0;       // Direction bit

    // =========================================================
    // Bit counter marks within one byte frame
    localparam logic [3:0]  BIT_FIRST = 4'h0;    // First data bit
    localparam logic [3:0]  BIT_LAST  = 4'h7;    // Eighth data bit
    localparam logic [3:0]  BIT_ACK   = 4'h8;    // Acknowledge slot

    // =========================================================
    // Reset values
    localparam logic [10:0] ADDR_RST  = 11'h000; // Address latch at power-on
    localparam logic [2:0]  PAGE_RST  = 3'h0;    // Page select at every link reset

    // =========================================================
    // Link states, Gray coded along address -> word -> data
    typedef enum logic [2:0] {
        ST_ADDR   = 3'h0,                        // Taking slave address
        ST_WADDR  = 3'h1,                        // Taking word address
        ST_WDATA  = 3'h3,                        // Taking write data
        ST_RDATA  = 3'h2,                        // Sending read data
        ST_IGNORE = 3'h6                         // Off the bus until start
    } smem_state_t;

endpackage

/* tb/smem_bus_master.sv */
`timescale 1ns/1ns
// =====
// Bus master model; clock only runs inside frames
module smem_bus_master (
    output logic      scl_out,    // Serial clock
    output logic      sda_oe_out, // Pulls data low
    input  wire logic sda_in      // Resolved data
);
    // Clock idles high, data released
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // One 80 ns slot: change data while low, sample while high
    task automatic bit_slot(input logic b, output logic s);
        #20 sda_oe_out = !b;
        #20 scl_out = 1'b1;
        #20 s = sda_in;
        #20 scl_out = 1'b0;
    endtask
    // Data falls with clock high
    task automatic start_ev;
        #20 sda_oe_out = 1'b0;
        #20 scl_out = 1'b1;
        #40 sda_oe_out = 1'b1;
        #40 scl_out = 1'b0;
    endtask
    // Data rises with clock high
    task automatic stop_ev;
        #20 sda_oe_out = 1'b1;
        #20 scl_out = 1'b1;
        #40 sda_oe_out = 1'b0;
        #40;
    endtask
    // Send one byte and sample the answer slot
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
        bit_slot(1'b1, s);
        ack = !s;
    endtask
    // Receive one byte, then answer it
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
        bit_slot(last, s);
    endtask
endmodule

/* tb/smem_i2c_slave_assertions.sv */
`timescale 1ns/1ns
// =====
// Port checker for the serial memory slave
module smem_i2c_slave_assertions
    import smem_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = 4'h5 // Device type, value arbitrary
) (
    input  wire logic clk_sys_in,         // System clock
    input  wire logic nrst_in,            // Reset, active low
    input  wire logic scl_clk_in,         // Serial clock
    input  wire logic sda_in,             // Resolved data
    input  wire logic sda_out,            // Drive value
    input  wire logic sda_oe_out,         // Drive enable
    input  wire logic bus_busy_out        // Busy flag
);
    // =====
    // All checks sample on the system clock
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    AST_DRIVE_ZERO: assert property (sda_out == 1'b0)
        else $error("Data drive value is not low");
    AST_OE_ON_LOW: assert property ($changed(sda_oe_out) |-> !scl_clk_in)
        else $error("Data drive changed while clock high");
    AST_OE_HIGH_STABLE: assert property ($rose(scl_clk_in) |=> $stable(sda_oe_out)[*2])
        else $error("Data drive moved in clock high phase");
    AST_START_BUSY: assert property ($fell(sda_in) && scl_clk_in && $past(scl_clk_in)
        |-> ##[1:6] bus_busy_out)
        else $error("Start not seen");
    AST_STOP_IDLE: assert property ($rose(sda_in) && scl_clk_in && $past(scl_clk_in)
        |-> ##[1:6] !bus_busy_out)
        else $error("Stop not seen");
    AST_IDLE_QUIET: assert property (!bus_busy_out |-> !sda_oe_out)
        else $error("Data driven while bus idle");
    AST_ACK_STANDS: assert property ($rose(sda_oe_out) |-> sda_oe_out[*6])
        else $error("Data drive shorter than a clock period");
    AST_START_FREE: assert property ($fell(sda_in) && scl_clk_in
        |-> !sda_oe_out[*4])
        else $error("Data driven just after start");
endmodule

bind smem_i2c_slave smem_i2c_slave_assertions #(.DEV_TYPE(DEV_TYPE)) u_chk (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .scl_clk_in(scl_clk_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .bus_busy_out(bus_busy_out));

/* tb/smem_i2c_slave_bench.sv */
`timescale 1ns/1ns
// =====
// Bench for the serial memory slave
module smem_i2c_slave_bench;
    localparam logic [3:0] DT = 4'h5; // Device type, value arbitrary
    logic       clk_sys_in = 1'b0;    // System clock
    logic       nrst_in    = 1'b0;    // Reset, active low
    wire logic  scl;                  // Serial clock
    wire logic  sda;                  // Resolved data wire
    wire logic  sda_o;                // Device drive value
    wire logic  sda_oe;               // Device drive enable
    wire logic  busy;                 // Device busy flag
    wire logic  m_oe;                 // Master pulls low
    int         errors    = 0;        // Mismatches
    int         cmp_count = 0;        // Comparisons
    logic       ak;                   // Answer slot seen
    logic [7:0] rd;                   // Byte read back
    // Open drain with pull-up
    assign sda = (sda_oe ? sda_o : 1'b1) & !m_oe;
    always #5 clk_sys_in = ~clk_sys_in;
    smem_i2c_slave #(.DEV_TYPE(DT)) dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .scl_clk_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
        .bus_busy_out(busy));
    smem_bus_master m (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda));
    // =====
    // Compare, verdict and bus steps
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("Compared %0d, mismatched %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Start plus slave address, expecting answer a
    task automatic adr(input logic [3:0] ty, input logic [2:0] pg, input logic r, input logic a);
        m.start_ev;
        m.put_byte({ty, pg, r}, ak);
        chk("addr ack", {7'h0, a}, {7'h0, ak});
        chk("busy", 8'h01, {7'h0, busy});
    endtask
    // Load the address latch, no stop
    task automatic sel(input logic [2:0] pg, input logic [7:0] wa);
        adr(DT, pg, 1'b0, 1'b1);
        m.put_byte(wa, ak);
        chk("word ack", 8'h01, {7'h0, ak});
    endtask
    // Write n counting bytes from d
    task automatic wr(input logic [2:0] pg, input logic [7:0] wa, input logic [7:0] d, input int n);
        sel(pg, wa);
        for (int i = 0; i < n; i++) begin
            m.put_byte(d + 8'(i), ak);
            chk("data ack", 8'h01, {7'h0, ak});
        end
        m.stop_ev;
        repeat (8) @(negedge clk_sys_in);
        chk("idle", 8'h00, {7'h0, busy});
    endtask
    // Current address read of n counting bytes
    task automatic cur_rd(input logic [2:0] pg, input logic [7:0] d, input int n);
        adr(DT, pg, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            m.get_byte(i == n - 1, rd);
            chk("read data", d + 8'(i), rd);
        end
        m.stop_ev;
    endtask
    // =====
    // Scenarios
    task automatic t_seq;
        wr(3'h5, 8'hFE, 8'h11, 3);
        sel(3'h5, 8'hFE);
        cur_rd(3'h5, 8'h11, 3);
        $display("Sequential test done");
    endtask
    task automatic t_wrap;
        wr(3'h7, 8'hFF, 8'hA0, 2);
        sel(3'h7, 8'hFF);
        cur_rd(3'h7, 8'hA0, 2);
        $display("Wrap test done");
    endtask
    task automatic t_page;
        wr(3'h1, 8'h81, 8'h44, 1);
        wr(3'h6, 8'h80, 8'h55, 1);
        cur_rd(3'h1, 8'h44, 1);
        $display("Page test done");
    endtask
    task automatic t_abort;
        logic s;
        sel(3'h1, 8'h81);
        for (int i = 0; i < 4; i++) m.bit_slot(1'b0, s);
        m.stop_ev;
        sel(3'h1, 8'h81);
        for (int i = 0; i < 6; i++) m.bit_slot(1'b0, s);
        adr(DT, 3'h1, 1'b1, 1'b1);
        m.get_byte(1'b1, rd);
        chk("kept data", 8'h44, rd);
        m.get_byte(1'b1, rd);
        chk("after nack", 8'hFF, rd);
        m.stop_ev;
        $display("Abort test done");
    endtask
    task automatic t_type;
        adr(DT ^ 4'h1, 3'h1, 1'b0, 1'b0);
        m.put_byte(8'h81, ak);
        chk("ignored ack", 8'h00, {7'h0, ak});
        m.stop_ev;
        adr(DT ^ 4'h8, 3'h1, 1'b1, 1'b0);
        m.get_byte(1'b1, rd);
        chk("ignored read", 8'hFF, rd);
        m.stop_ev;
        $display("Type test done");
    endtask
    // Hang guard
    initial begin
        repeat (90000) @(posedge clk_sys_in);
        errors++;
        give_verdict;
    end
    // Main sequence
    initial begin
        repeat (10) @(negedge clk_sys_in);
        nrst_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        t_seq;
        t_wrap;
        t_page;
        t_abort;
        t_type;
        give_verdict;
    end
endmodule
